// *** long_sleep_regs.vh ***
`ifndef LONG_SLEEP_REGS_VH
`define LONG_SLEEP_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define REG_CTRL 8'h00
`define REG_LIMIT 8'h04
`define REG_DFLT 8'h08
`define REG_STATUS 8'h0C

// ****************************************
// Control fields and reset values
// ****************************************
`define CTRL_ENABLE 0
`define CTRL_DENY_ALL 1
`define CTRL_AUX_LO 4
`define CTRL_AUX_HI 6
`define CTRL_UPD_MODE 7
`define CTRL_CAUSE_LO 8
`define CTRL_CAUSE_HI 11
`define CTRL_RESET 32'h000000B1
`define LIMIT_RESET 16'h0F00
`define DFLT_RESET 16'h0010
`define AUX_MIN 3'h3

// ****************************************
// Message layout
// ****************************************
`define TYPE_ONE_SHOT 3'h0
`define TYPE_REPEAT 3'h1
`define TYPE_CANCEL 3'h2
`define SPAN_STANDBY 16'hFFFF
`define SPAN_ONE_CYCLE 16'h0010
`define MSG_OCTETS 3'h5

// ****************************************
// Denial causes
// ****************************************
`define CAUSE_NONE 4'h0
`define CAUSE_TOO_LONG 4'h1
`define CAUSE_TOO_SHORT 4'h2
`define CAUSE_SCHED_FAIL 4'h3
`define CAUSE_SCHED_RETRY 4'h4
`define CAUSE_TOPO_FAIL 4'h5
`define CAUSE_TOPO_RETRY 4'h6

// ****************************************
// Node phases
// ****************************************
`define PH_IDLE 2'h0
`define PH_WAIT 2'h1
`define PH_SLEEP 2'h2
`define PH_AWAKE 2'h3

`endif

// *** span_check.v ***
`timescale 1ns/1ps
`include "long_sleep_regs.vh"

module span_check (
    // Span under test
    input wire [15:0] span_i,
    input wire [15:0] limit_i,
    input wire allow_standby_i,
    // Verdict
    output reg ok_o,
    output reg [3:0] cause_o
);

always @* begin
    ok_o = 1'b0;
    cause_o = `CAUSE_NONE;
    if (span_i == 16'h0000) begin
        ok_o = 1'b1;
    end else if (allow_standby_i && span_i == `SPAN_STANDBY) begin
        ok_o = 1'b1;
    end else if (span_i < `SPAN_ONE_CYCLE) begin
        cause_o = `CAUSE_TOO_SHORT;
    end else if (span_i > limit_i) begin
        cause_o = `CAUSE_TOO_LONG;
    end else if (span_i[3:0] != 4'h0) begin
        // Partial cycles cannot end on a MAC cycle boundary
        cause_o = `CAUSE_SCHED_FAIL;
    end else begin
        ok_o = 1'b1;
    end
end

endmodule // span_check

// *** long_sleep_sched.v ***
`timescale 1ns/1ps
`include "long_sleep_regs.vh"

module long_sleep_sched (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Long sleep request payload, one octet per beat
    input wire msg_valid_i,
    input wire [7:0] msg_byte_i,
    input wire msg_last_i,
    output wire msg_ready_o,
    // MAC cycle start on the transmit clock
    input wire mac_tick_i,
    // Schedule announcement
    output reg ann_valid_o,
    output reg [2:0] ann_type_o,
    output reg [15:0] ann_start_o,
    output reg [15:0] ann_inact_o,
    output reg [15:0] ann_awake_o,
    output reg [2:0] ann_aux_valid_o,
    output reg ann_update_mode_o,
    // Long sleep denial
    output reg deny_valid_o,
    output reg [7:0] deny_octet_o,
    // Default sleep cycle
    output reg [15:0] dflt_cycle_o,
    output reg [15:0] dflt_next_o,
    // Tracked node state
    output reg node_asleep_o,
    output reg node_standby_o
);

localparam ST_COLLECT = 2'h0;
localparam ST_CHECK = 2'h1;
localparam ST_EMIT = 2'h2;

// ****************************************
// Registers of the software interface
// ****************************************
reg [31:0] ctrl_r;
reg [15:0] limit_r;
reg [15:0] dflt_len_r;
reg [3:0] last_cause_r;
reg denied_r;
reg [15:0] mac_count_r;

// ****************************************
// Request assembly and decision
// ****************************************
reg [1:0] state_r;
reg [2:0] idx_r;
reg [7:0] type_oct_r;
reg [15:0] inact_r;
reg [15:0] awake_r;
reg short_r;
reg accept_r;
reg [3:0] cause_r;

// ****************************************
// Node tracking
// ****************************************
reg [1:0] phase_r;
reg [15:0] lead_r;
reg [11:0] rem_r;
reg [2:0] sch_type_r;
reg [11:0] sch_inact_r;
reg [11:0] sch_awake_r;
reg sch_standby_r;

// ****************************************
// Decision helpers
// ****************************************
wire in_ok;
wire [3:0] in_cause;
wire aw_ok;
wire [3:0] aw_cause;
wire [2:0] req_type;
wire [2:0] aux_cnt;
wire upd_mode;
wire [15:0] lead_cycles;
wire wb_req;
wire [3:0] forced_cause;

assign req_type = type_oct_r[2:0];
assign aux_cnt = (ctrl_r[`CTRL_AUX_HI:`CTRL_AUX_LO] < `AUX_MIN) ? `AUX_MIN : ctrl_r[`CTRL_AUX_HI:`CTRL_AUX_LO];
assign upd_mode = ctrl_r[`CTRL_UPD_MODE];
// Validity counter delays the switch by its count, immediate by one cycle
// Sleep never starts in the current cycle, so its exchanges can finish
assign lead_cycles = upd_mode ? {13'h0000, aux_cnt} : 16'h0001;
assign msg_ready_o = (state_r == ST_COLLECT);
assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
// Codes beyond the defined set would leave the node guessing
assign forced_cause = (ctrl_r[`CTRL_CAUSE_HI:`CTRL_CAUSE_LO] > `CAUSE_TOPO_RETRY) ? `CAUSE_NONE :
    ctrl_r[`CTRL_CAUSE_HI:`CTRL_CAUSE_LO];

span_check u_inact_check (
    .span_i(inact_r),
    .limit_i(limit_r),
    .allow_standby_i(1'b1),
    .ok_o(in_ok),
    .cause_o(in_cause)
);

// Awake span has no standby meaning and no re-registration bound
span_check u_awake_check (
    .span_i(awake_r),
    .limit_i(16'hFFFE),
    .allow_standby_i(1'b0),
    .ok_o(aw_ok),
    .cause_o(aw_cause)
);

// ****************************************
// Wishbone slave
// ****************************************
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        ctrl_r <= `CTRL_RESET;
        limit_r <= `LIMIT_RESET;
        dflt_len_r <= `DFLT_RESET;
    end else begin
        // Registered ack: at most one access every two cycles
        wb_ack_o <= wb_req;
        if (wb_req) begin
            wb_dat_o <= 32'h00000000;
            if (wb_adr_i == `REG_CTRL) begin
                wb_dat_o <= ctrl_r;
                if (wb_we_i) begin
                    if (wb_sel_i[0]) ctrl_r[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) ctrl_r[15:8] <= {4'h0, wb_dat_i[11:8]};
                end
            end else if (wb_adr_i == `REG_LIMIT) begin
                wb_dat_o <= {16'h0000, limit_r};
                if (wb_we_i && wb_sel_i[0]) limit_r[7:0] <= wb_dat_i[7:0];
                if (wb_we_i && wb_sel_i[1]) limit_r[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i == `REG_DFLT) begin
                wb_dat_o <= {16'h0000, dflt_len_r};
                if (wb_we_i && wb_sel_i[0]) dflt_len_r[7:0] <= wb_dat_i[7:0];
                if (wb_we_i && wb_sel_i[1]) dflt_len_r[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i == `REG_STATUS) begin
                wb_dat_o <= {4'h0, rem_r, 9'h000, denied_r, last_cause_r, phase_r};
            end
        end
    end
end

// ****************************************
// Default sleep cycle on the transmit clock
// ****************************************
always @(posedge clk_i) begin
    if (rst_i) begin
        mac_count_r <= 16'h0000;
        dflt_cycle_o <= `DFLT_RESET;
        dflt_next_o <= `DFLT_RESET;
    end else begin
        dflt_cycle_o <= dflt_len_r;
        if (mac_tick_i) begin
            // Start times compare by difference, so a wrap is harmless
            mac_count_r <= mac_count_r + 16'h0001;
            if (dflt_next_o <= 16'h0001) begin
                dflt_next_o <= dflt_len_r;
            end else begin
                dflt_next_o <= dflt_next_o - 16'h0001;
            end
        end
    end
end

// ****************************************
// Request collection, check and reply
// ****************************************
always @(posedge clk_i) begin
    if (rst_i) begin
        state_r <= ST_COLLECT;
        idx_r <= 3'h0;
        type_oct_r <= 8'h00;
        inact_r <= 16'h0000;
        awake_r <= 16'h0000;
        short_r <= 1'b0;
        accept_r <= 1'b0;
        cause_r <= `CAUSE_NONE;
        last_cause_r <= `CAUSE_NONE;
        denied_r <= 1'b0;
        ann_valid_o <= 1'b0;
        ann_type_o <= `TYPE_ONE_SHOT;
        ann_start_o <= 16'h0000;
        ann_inact_o <= 16'h0000;
        ann_awake_o <= 16'h0000;
        ann_aux_valid_o <= 3'h0;
        ann_update_mode_o <= 1'b0;
        deny_valid_o <= 1'b0;
        deny_octet_o <= 8'h00;
    end else begin
        ann_valid_o <= 1'b0;
        deny_valid_o <= 1'b0;
        case (state_r)
            ST_COLLECT: begin
                if (msg_valid_i && ctrl_r[`CTRL_ENABLE]) begin
                    if (idx_r == 3'h0) type_oct_r <= msg_byte_i;
                    if (idx_r == 3'h1) inact_r[7:0] <= msg_byte_i;
                    if (idx_r == 3'h2) inact_r[15:8] <= msg_byte_i;
                    if (idx_r == 3'h3) awake_r[7:0] <= msg_byte_i;
                    if (idx_r == 3'h4) awake_r[15:8] <= msg_byte_i;
                    // Octets past the fifth are dropped
                    if (idx_r < `MSG_OCTETS) idx_r <= idx_r + 3'h1;
                    if (msg_last_i) begin
                        short_r <= (idx_r < (`MSG_OCTETS - 3'h1));
                        idx_r <= 3'h0;
                        state_r <= ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                accept_r <= 1'b0;
                cause_r <= `CAUSE_NONE;
                // First failing check decides the cause
                if (short_r) begin
                    cause_r <= `CAUSE_NONE;
                end else if (ctrl_r[`CTRL_DENY_ALL]) begin
                    cause_r <= forced_cause;
                end else if (req_type == `TYPE_CANCEL) begin
                    accept_r <= 1'b1;
                end else if (req_type != `TYPE_ONE_SHOT && req_type != `TYPE_REPEAT) begin
                    cause_r <= `CAUSE_NONE;
                end else if (inact_r == 16'h0000) begin
                    cause_r <= `CAUSE_TOO_SHORT;
                end else if (!in_ok) begin
                    cause_r <= in_cause;
                end else if (req_type == `TYPE_REPEAT && (awake_r == 16'h0000 || !aw_ok)) begin
                    cause_r <= (awake_r == 16'h0000) ? `CAUSE_TOO_SHORT : aw_cause;
                end else if (req_type == `TYPE_REPEAT && inact_r == `SPAN_STANDBY) begin
                    cause_r <= `CAUSE_SCHED_FAIL;
                end else begin
                    accept_r <= 1'b1;
                end
                state_r <= ST_EMIT;
            end
            ST_EMIT: begin
                if (accept_r) begin
                    ann_valid_o <= 1'b1;
                    ann_type_o <= req_type;
                    ann_start_o <= mac_count_r + lead_cycles;
                    ann_inact_o <= (req_type == `TYPE_CANCEL) ? 16'h0000 : inact_r;
                    ann_awake_o <= (req_type == `TYPE_REPEAT) ? awake_r : 16'h0000;
                    ann_aux_valid_o <= upd_mode ? aux_cnt : 3'h0;
                    ann_update_mode_o <= upd_mode;
                end else begin
                    deny_valid_o <= 1'b1;
                    deny_octet_o <= {4'h0, cause_r};
                    last_cause_r <= cause_r;
                    denied_r <= 1'b1;
                end
                state_r <= ST_COLLECT;
            end
            default: begin
                state_r <= ST_COLLECT;
            end
        endcase
    end
end

// ****************************************
// Node phase tracking
// ****************************************
always @(posedge clk_i) begin
    if (rst_i) begin
        phase_r <= `PH_IDLE;
        lead_r <= 16'h0000;
        rem_r <= 12'h000;
        sch_type_r <= `TYPE_ONE_SHOT;
        sch_inact_r <= 12'h000;
        sch_awake_r <= 12'h000;
        sch_standby_r <= 1'b0;
        node_asleep_o <= 1'b0;
        node_standby_o <= 1'b0;
    end else begin
        if (mac_tick_i) begin
            // Every phase change in this case lands on a MAC cycle start; an announcement below changes the phase at once
            case (phase_r)
                `PH_WAIT: begin
                    if (lead_r <= 16'h0001) begin
                        phase_r <= `PH_SLEEP;
                        rem_r <= sch_inact_r;
                    end else begin
                        lead_r <= lead_r - 16'h0001;
                    end
                end
                `PH_SLEEP: begin
                    if (!sch_standby_r && rem_r <= 12'h001) begin
                        if (sch_type_r == `TYPE_REPEAT) begin
                            phase_r <= `PH_AWAKE;
                            rem_r <= sch_awake_r;
                        end else begin
                            phase_r <= `PH_IDLE;
                            rem_r <= 12'h000;
                        end
                    end else if (!sch_standby_r) begin
                        rem_r <= rem_r - 12'h001;
                    end
                end
                `PH_AWAKE: begin
                    if (rem_r <= 12'h001) begin
                        phase_r <= `PH_SLEEP;
                        rem_r <= sch_inact_r;
                    end else begin
                        rem_r <= rem_r - 12'h001;
                    end
                end
                default: begin
                    phase_r <= `PH_IDLE;
                end
            endcase
        end
        // A new announcement replaces whatever was running
        if (ann_valid_o) begin
            sch_type_r <= ann_type_o;
            // Accepted spans are whole cycles, so the sixteenths are dropped
            sch_inact_r <= ann_inact_o[15:4];
            sch_awake_r <= ann_awake_o[15:4];
            sch_standby_r <= (ann_inact_o == `SPAN_STANDBY);
            lead_r <= ann_start_o - mac_count_r;
            rem_r <= 12'h000;
            phase_r <= (ann_type_o == `TYPE_CANCEL) ? `PH_IDLE : `PH_WAIT;
        end
        node_asleep_o <= (phase_r == `PH_SLEEP);
        // Standby lasts until the controller announces again
        node_standby_o <= (phase_r == `PH_SLEEP) && sch_standby_r;
    end
end

endmodule // long_sleep_sched

// *** long_sleep_sched_assertions.sv ***
`timescale 1ns/1ps
// ********
// Checker
// ********
module long_sleep_sched_checker (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Observed ports
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire msg_valid_i,
    input wire msg_last_i,
    input wire msg_ready_o,
    input wire mac_tick_i,
    input wire ann_valid_o,
    input wire [2:0] ann_type_o,
    input wire [15:0] ann_inact_o,
    input wire [15:0] ann_awake_o,
    input wire [2:0] ann_aux_valid_o,
    input wire ann_update_mode_o,
    input wire deny_valid_o,
    input wire [7:0] deny_octet_o,
    input wire node_asleep_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
    property p_resp;
        msg_valid_i && msg_ready_o && msg_last_i |=> !msg_ready_o [*2] ##1 (ann_valid_o || deny_valid_o);
    endproperty
    a_resp: assert property (p_resp) else $error("no answer to request");
    property p_one;
        !(ann_valid_o && deny_valid_o);
    endproperty
    a_one: assert property (p_one) else $error("announce and denial together");
    property p_pulse;
        ann_valid_o |=> !ann_valid_o && !deny_valid_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("announce pulse too long");
    property p_deny;
        deny_valid_o |-> deny_octet_o[7:4] == 4'h0 && deny_octet_o[3:0] <= 4'h6;
    endproperty
    a_deny: assert property (p_deny) else $error("bad denial octet");
    property p_type0;
        ann_valid_o && ann_type_o == 3'h0 |-> ann_awake_o == 16'h0000;
    endproperty
    a_type0: assert property (p_type0) else $error("one-shot awake span not zero");
    property p_cancel;
        ann_valid_o && ann_type_o == 3'h2 |-> ann_inact_o == 16'h0000 && ann_awake_o == 16'h0000;
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel spans not zero");
    property p_span;
        ann_valid_o && ann_type_o != 3'h2 |->
            (ann_inact_o >= 16'h0010 && ann_inact_o[3:0] == 4'h0) || ann_inact_o == 16'hFFFF;
    endproperty
    a_span: assert property (p_span) else $error("bad inactive span");
    property p_aux;
        ann_valid_o |-> (ann_update_mode_o ? ann_aux_valid_o >= 3'h3 : ann_aux_valid_o == 3'h0);
    endproperty
    a_aux: assert property (p_aux) else $error("bad validity count");
    property p_tick;
        $rose(node_asleep_o) |-> $past(mac_tick_i, 2);
    endproperty
    a_tick: assert property (p_tick) else $error("sleep not at cycle start");
endmodule // long_sleep_sched_checker

bind long_sleep_sched long_sleep_sched_checker long_sleep_sched_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .msg_valid_i(msg_valid_i),
    .msg_last_i(msg_last_i), .msg_ready_o(msg_ready_o), .mac_tick_i(mac_tick_i), .ann_valid_o(ann_valid_o),
    .ann_type_o(ann_type_o), .ann_inact_o(ann_inact_o), .ann_awake_o(ann_awake_o),
    .ann_aux_valid_o(ann_aux_valid_o), .ann_update_mode_o(ann_update_mode_o), .deny_valid_o(deny_valid_o),
    .deny_octet_o(deny_octet_o), .node_asleep_o(node_asleep_o));

// *** node_model.sv ***
`timescale 1ns/1ps
// ********
// Node
// ********
module node_model (
    input wire clk_i,
    input wire msg_ready_i,
    output reg msg_valid_o,
    output reg [7:0] msg_byte_o,
    output reg msg_last_o
);
    initial begin
        msg_valid_o = 1'b0;
        msg_byte_o = 8'hA5;
        msg_last_o = 1'b0;
    end
    // Nonzero rsv only where a scenario probes the receiver
    task send(input [2:0] typ, input [4:0] rsv, input [15:0] inact, input [15:0] awake, input integer n);
        reg [39:0] pl;
        integer i;
        begin
            pl = {awake, inact, rsv, typ};
            for (i = 0; i < n; i = i + 1) begin
                msg_valid_o <= 1'b1;
                msg_byte_o <= pl[8*i +: 8];
                msg_last_o <= (i == n - 1);
                @(posedge clk_i);
                while (msg_ready_i !== 1'b1) @(posedge clk_i);
            end
            msg_valid_o <= 1'b0;
            msg_last_o <= 1'b0;
            // Released bus must not keep the last octet
            msg_byte_o <= ~msg_byte_o;
        end
    endtask
endmodule // node_model

// *** tb_long_sleep_sched.sv ***
`timescale 1ns/1ps
// ********
// Bench
// ********
module tb_long_sleep_sched;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, mac_tick_i = 1'b0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [3:0] wb_sel_i = 4'hF;
    reg [31:0] wb_dat_i = 32'h0;
    reg [2:0] tick_cnt = 3'h0;
    reg [15:0] ticks = 16'h0000, ticks_d = 16'h0000, st = 16'h0000;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, msg_valid_i, msg_last_i, msg_ready_o, ann_valid_o, ann_update_mode_o, deny_valid_o;
    wire [7:0] msg_byte_i, deny_octet_o;
    wire [2:0] ann_type_o, ann_aux_valid_o;
    wire [15:0] ann_start_o, ann_inact_o, ann_awake_o, dflt_cycle_o, dflt_next_o;
    wire node_asleep_o, node_standby_o;
    integer miscompares = 0, cmp_count = 0, c;
    reg ok;
    reg [31:0] q;
    long_sleep_sched long_sleep_sched_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .msg_valid_i(msg_valid_i), .msg_byte_i(msg_byte_i), .msg_last_i(msg_last_i),
        .msg_ready_o(msg_ready_o), .mac_tick_i(mac_tick_i), .ann_valid_o(ann_valid_o), .ann_type_o(ann_type_o),
        .ann_start_o(ann_start_o), .ann_inact_o(ann_inact_o), .ann_awake_o(ann_awake_o),
        .ann_aux_valid_o(ann_aux_valid_o), .ann_update_mode_o(ann_update_mode_o), .deny_valid_o(deny_valid_o),
        .deny_octet_o(deny_octet_o), .dflt_cycle_o(dflt_cycle_o), .dflt_next_o(dflt_next_o),
        .node_asleep_o(node_asleep_o), .node_standby_o(node_standby_o));
    node_model node_model_i (.clk_i(clk_i), .msg_ready_i(msg_ready_o), .msg_valid_o(msg_valid_i),
        .msg_byte_o(msg_byte_i), .msg_last_o(msg_last_i));
    always #20 clk_i = ~clk_i;
    // Cycle start every 8 clocks keeps sleep spans short
    always @(posedge clk_i) begin
        tick_cnt <= tick_cnt + 3'h1;
        mac_tick_i <= (tick_cnt == 3'h7);
        ticks <= rst_i ? 16'h0000 : ticks + {15'h0000, mac_tick_i};
        ticks_d <= ticks;
    end
    task check(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wb(input we, input [7:0] a, input [31:0] d);
        begin
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= a;
            wb_dat_i <= d;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1) @(posedge clk_i);
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task req(input [2:0] t, input [4:0] r, input [15:0] in, input [15:0] aw, input integer n);
        integer k;
        begin
            node_model_i.send(t, r, in, aw, n);
            k = 0;
            while (ann_valid_o !== 1'b1 && deny_valid_o !== 1'b1 && k < 20) begin
                @(posedge clk_i);
                k = k + 1;
            end
            ok = ann_valid_o;
            st = ticks_d;
            if (k == 20) check(32'h0, 32'h1);
            @(posedge clk_i);
        end
    endtask
    task deny_case(input [2:0] t, input [15:0] in, input [15:0] aw, input integer n, input [3:0] cause);
        begin
            req(t, 5'h00, in, aw, n);
            check(32'(ok), 32'h0);
            check(32'(deny_octet_o), 32'(cause));
        end
    endtask
    task wait_sleep(input v, input integer lim);
        integer k;
        begin
            k = 0;
            while (node_asleep_o !== v && k < lim) begin
                @(posedge clk_i);
                k = k + 1;
            end
            check(32'(node_asleep_o), 32'(v));
        end
    endtask
    task t_regs;
        begin
            wb(1'b0, 8'h00, 32'h0);
            check(q, 32'h000000B1);
            wb(1'b0, 8'h04, 32'h0);
            check(q, 32'h00000F00);
            wb(1'b0, 8'h08, 32'h0);
            check(q, 32'h00000010);
            check({16'h0000, dflt_cycle_o}, 32'h00000010);
            check({16'h0000, dflt_next_o}, {16'h0000, 16'h0010 - {12'h000, ticks[3:0]}});
            wb(1'b0, 8'h20, 32'h0);
            check(q, 32'h0);
            wb(1'b1, 8'h04, 32'h00000100);
            wb(1'b0, 8'h04, 32'h0);
            check(q, 32'h00000100);
        end
    endtask
    task t_deny;
        begin
            deny_case(3'h0, 16'h0020, 16'h0, 3, 4'h0);
            deny_case(3'h5, 16'h0020, 16'h0, 5, 4'h0);
            deny_case(3'h0, 16'h0000, 16'h0, 5, 4'h2);
            deny_case(3'h0, 16'h0008, 16'h0, 5, 4'h2);
            deny_case(3'h0, 16'h0200, 16'h0, 5, 4'h1);
            deny_case(3'h0, 16'h0018, 16'h0, 5, 4'h3);
            deny_case(3'h1, 16'h0010, 16'h0008, 5, 4'h2);
            deny_case(3'h1, 16'hFFFF, 16'h0010, 5, 4'h3);
            for (c = 4; c < 8; c = c + 1) begin
                wb(1'b1, 8'h00, 32'h000000B3 | (c << 8));
                deny_case(3'h0, 16'h0020, 16'h0, 5, (c == 7) ? 4'h0 : c[3:0]);
            end
            wb(1'b0, 8'h0C, 32'h0);
            check({27'h0000000, q[6:2]}, 32'h00000010);
            wb(1'b1, 8'h00, 32'h000000B1);
        end
    endtask
    task t_oneshot;
        begin
            req(3'h0, 5'h1F, 16'h0020, 16'h0030, 5);
            check(32'(ok), 32'h1);
            check({13'h0000, ann_type_o, ann_inact_o}, {13'h0000, 3'h0, 16'h0020});
            check({16'h0000, ann_awake_o}, 32'h00000000);
            check({28'h0000000, ann_aux_valid_o, ann_update_mode_o}, {28'h0000000, 3'h3, 1'b1});
            check({16'h0000, ann_start_o}, {16'h0000, st + 16'h0003});
            wait_sleep(1'b1, 100);
            wait_sleep(1'b0, 60);
            repeat (12) @(posedge clk_i);
            wb(1'b0, 8'h0C, 32'h0);
            check({30'h00000000, q[1:0]}, 32'h00000000);
        end
    endtask
    task t_repeat;
        begin
            req(3'h1, 5'h00, 16'h0010, 16'h0030, 5);
            check({12'h000, ok, ann_type_o, ann_awake_o}, {12'h000, 1'b1, 3'h1, 16'h0030});
            wait_sleep(1'b1, 100);
            wait_sleep(1'b0, 40);
            wait_sleep(1'b1, 60);
            wait_sleep(1'b0, 40);
            req(3'h2, 5'h00, 16'h0, 16'h0, 5);
            check({28'h0000000, ok, ann_type_o}, {28'h0000000, 1'b1, 3'h2});
            repeat (60) @(posedge clk_i);
            check(32'(node_asleep_o), 32'h0);
        end
    endtask
    task t_standby;
        begin
            wb(1'b1, 8'h00, 32'h00000001);
            req(3'h0, 5'h00, 16'hFFFF, 16'h0, 5);
            check({27'h0000000, ok, ann_aux_valid_o, ann_update_mode_o}, {27'h0000000, 1'b1, 3'h0, 1'b0});
            check({16'h0000, ann_start_o}, {16'h0000, st + 16'h0001});
            wait_sleep(1'b1, 40);
            check(32'(node_standby_o), 32'h1);
        end
    endtask
    task final_report;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_deny;
        t_oneshot;
        t_repeat;
        t_standby;
        final_report;
    end
    initial begin
        #800000;
        miscompares = miscompares + 1;
        final_report;
    end
endmodule // tb_long_sleep_sched
